// *** core/ich_pkg.sv ***
// package of constants for the immediate command handler
package ich_pkg;
    // command codes
    localparam logic [7:0] ICH_CMD_RESTART  = 8'h04;
    localparam logic [7:0] ICH_CMD_VERSION  = 8'h05;
    localparam logic [7:0] ICH_CMD_BUFREAD  = 8'h06;
    localparam logic [7:0] ICH_CMD_RUN      = 8'h0a;
    localparam logic [7:0] ICH_CMD_REGREAD  = 8'h0c;
    localparam logic [7:0] ICH_CMD_MODIFY   = 8'h20;
    localparam logic [7:0] ICH_CMD_END      = 8'h00;
    // modify operation selectors
    localparam logic [2:0] ICH_OP_OR        = 3'h0;
    localparam logic [2:0] ICH_OP_CLEAR     = 3'h1;
    localparam logic [2:0] ICH_OP_AND       = 3'h2;
    localparam logic [2:0] ICH_OP_XOR       = 3'h3;
    localparam logic [2:0] ICH_OP_ADD       = 3'h4;
    // buffer read length limits
    localparam logic [3:0] ICH_BUF_LEN_MIN  = 4'h1;
    localparam logic [3:0] ICH_BUF_LEN_MAX  = 4'h8;
    // most registers selectable by one register read
    localparam logic [2:0] ICH_REGREAD_MAX  = 3'h4;
    // buffer word layout: command code in bits 15:8, its top bit at 15
    localparam int         ICH_OPC_MSB      = 15;
    localparam int         ICH_OPC_LSB      = 8;
    // buffer size byte saturates here; true size in register 210 high word
    localparam logic [7:0] ICH_SIZE_SAT     = 8'hff;
    localparam logic [7:0] ICH_SIZE_REG     = 8'hd2;
    // answer kinds
    localparam logic [1:0] ICH_ANS_DATA     = 2'h0;
    localparam logic [1:0] ICH_ANS_ACK      = 2'h1;
    localparam logic [1:0] ICH_ANS_NAK_BUSY = 2'h2;
    // version reply fields (values arbitrary)
    localparam logic [7:0]  ICH_VER_MONTH   = 8'h01;
    localparam logic [7:0]  ICH_VER_DAY     = 8'h01;
    localparam logic [15:0] ICH_VER_YEAR    = 16'h2000;
    localparam logic [15:0] ICH_VER_REV     = 16'h0001; // arbitrary value
    localparam logic [7:0]  ICH_SER_SIZE    = 8'h0a;

    typedef enum logic [2:0] {
        ICH_IDLE, ICH_HEAD, ICH_BODY, ICH_MODIFY_WR
    } ich_state_t;
endpackage

// *** core/ich_regfile.sv ***
// data register file with one read port and one write port
`timescale 1ns/1ns
module ich_regfile
    import ich_pkg::*;
#(
    parameter int NREG = 256
) (
    input  wire logic               mclk,
    input  wire logic               clr,
    input  wire logic [7:0]         rd_sel,
    output logic      [31:0]        rd_data,
    input  wire logic               wr_en,
    input  wire logic [7:0]         wr_sel,
    input  wire logic [31:0]        wr_data,
    input  wire logic [15:0]        size_hi
);
    logic [31:0] mem_r [NREG];

    // clear all on restart, else write; register 210 high word pinned
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NREG; i++) begin
            if (clr) begin
                mem_r[i] <= '0;
            end else if (wr_en && wr_sel == 8'(i)) begin
                mem_r[i] <= wr_data;
            end
        end
    end

    // combinational read, size register reports true buffer size
    always_comb begin
        rd_data = mem_r[rd_sel];
        if (rd_sel == ICH_SIZE_REG) begin
            rd_data = {size_hi, mem_r[rd_sel][15:0]};
        end
    end
endmodule // ich_regfile

// *** core/ich_handler.sv ***
// immediate command handler: decodes framed commands, builds answers
//
// Overview of operation
// RULE1: buffer read (code 6) returns 1..8 words from given address.
// RULE2: returned command code words have their top bit inverted; here only host-mode command and end words are, loaded words return unchanged.
// RULE3: host reads a whole buffer with several buffer reads.
// RULE4: register read (code 12) accepted anytime, returns full 32 bits.
// RULE5: register read takes up to three extra selectors, four registers.
// RULE6: modify (code 32) answers old value, then updates register.
// RULE7: operation 0 or, 1 clear, 2 and, 3 xor, 4 add.
// RULE8: restart (code 4) clears registers, returns to address zero.
// RULE9: restart sends no answer at all.
// RULE10: run (code 10) leaves download, pointer to zero, starts program.
// RULE11: run while busy is answered with busy negative acknowledge.
// RULE12: host program command stored at buffer start, end after, then run.
// RULE13: last host program command stays until replaced or loaded.
// RULE14: version answers month, day, year, revision, two size bytes.
// RULE15: buffer of 255 words or more reports 255, true size in reg 210.
// RULE16: data answers start with unit address and command echo.
`timescale 1ns/1ns
module ich_handler
    import ich_pkg::*;
#(
    parameter int          PB_WORDS = 512,
    parameter logic [15:0] UNIT_ADDR = 16'h0010,
    parameter int          AW       = 9
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    // command frame in: one word per valid, word 0 is command code
    input  wire logic          cmd_valid,
    input  wire logic          cmd_first,
    input  wire logic          cmd_last,
    input  wire logic [15:0]   cmd_word,
    output logic               cmd_ready,
    // answer out
    output logic               ans_valid,
    output logic               ans_last,
    output logic [1:0]         ans_kind_r,
    output logic [15:0]        ans_word_r,
    input  wire logic          ans_ready,
    // program execution side
    input  wire logic          prog_busy,
    input  wire logic          host_mode,
    input  wire logic          prog_load,
    input  wire logic          load_we,
    input  wire logic [AW-1:0] load_addr,
    input  wire logic [15:0]   load_word,
    output logic               run_start_r,
    output logic [AW-1:0]      prog_ptr_r,
    output logic               download_r,
    input  wire logic          download_set,
    output logic               restart_r
);
    // buffer size byte and true size
    localparam logic [15:0] PB_SIZE = 16'(PB_WORDS);
    localparam logic [7:0]  PB_BYTE = (PB_WORDS >= 255) ? ICH_SIZE_SAT
                                      : 8'(PB_WORDS);

    ich_state_t    state_r;
    logic [15:0]   pbuf_r [PB_WORDS];
    logic          is_opc_r [PB_WORDS];
    logic [15:0]   words_r [8];
    logic [3:0]    nwords_r;
    logic [7:0]    opcode_r;
    logic [3:0]    out_idx_r;
    logic [3:0]    out_cnt_r;
    logic [15:0]   out_buf_r [18];
    logic [7:0]    rd_sel;
    logic [31:0]   rd_data;
    logic [31:0]   mod_val;
    logic          mod_we;
    logic [AW-1:0] pb_addr;
    logic [15:0]   pb_word;
    logic          host_cmd;
    logic [4:0]    rr_slot;

    // takes a command code's top bit and inverts it
    function automatic logic [15:0] flip_opc(input logic [15:0] w,
                                             input logic opc);
        flip_opc = w;
        if (opc) begin
            flip_opc[ICH_OPC_MSB] = ~w[ICH_OPC_MSB];
        end
    endfunction

    // operation decode of the modify command
    function automatic logic [31:0] modify(input logic [2:0] op,
                                           input logic [31:0] a,
                                           input logic [31:0] b);
        modify = a;
        case (op)
            ICH_OP_OR:    modify = a | b;
            ICH_OP_CLEAR: modify = a & ~b;
            ICH_OP_AND:   modify = a & b;
            ICH_OP_XOR:   modify = a ^ b;
            ICH_OP_ADD:   modify = a + b;
            default:      modify = a;
        endcase
    endfunction

    // data registers
    ich_regfile #(.NREG(256)) u_regs (
        .mclk    (mclk),
        .clr     (srst || restart_r),
        .rd_sel  (rd_sel),
        .rd_data (rd_data),
        .wr_en   (mod_we),
        .wr_sel  (words_r[2][7:0]),
        .wr_data (mod_val),
        .size_hi (PB_SIZE) // [RULE15]
    );

    // only the modify command writes back; register read leaves data alone
    assign mod_we  = (state_r == ICH_MODIFY_WR)
                     && (opcode_r == ICH_CMD_MODIFY);
    // answer slot of the register being read in this pass
    assign rr_slot = 5'h2 + {out_idx_r, 1'b0};
    // single program command in host mode, buffer not busy loading
    assign host_cmd = cmd_valid && cmd_ready && cmd_first && cmd_last
                      && host_mode && !prog_load && !load_we
                      && cmd_word[ICH_OPC_MSB];
    assign mod_val = modify(words_r[1][2:0], rd_data,
                            {words_r[3], words_r[4]}); // [RULE7]
    assign cmd_ready = (state_r == ICH_IDLE);
    assign ans_valid = (state_r == ICH_BODY);
    assign ans_last  = ans_valid && (out_idx_r + 4'h1 == out_cnt_r);

    // collect words of a frame
    always_ff @(posedge mclk) begin
        if (srst) begin
            nwords_r <= '0;
        end else if (cmd_valid && cmd_ready) begin
            if (cmd_first) begin
                nwords_r <= 4'h1;
            end else if (nwords_r < 4'h8) begin
                nwords_r <= nwords_r + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (cmd_valid && cmd_ready) begin
            if (cmd_first) begin
                words_r[0] <= cmd_word;
            end else if (nwords_r < 4'h8) begin
                words_r[nwords_r[2:0]] <= cmd_word;
            end
        end
    end

    // program buffer: loads, and host-mode single command plus end
    assign pb_addr = AW'(words_r[2]) ;
    always_ff @(posedge mclk) begin
        if (load_we) begin
            pbuf_r[load_addr]   <= load_word;
            is_opc_r[load_addr] <= 1'b0;
        end else if (host_cmd) begin
            pbuf_r[0]   <= cmd_word;          // [RULE12]
            is_opc_r[0] <= 1'b1;
            // end stored with top bit set, reads back as plain end code
            pbuf_r[1]   <= {ICH_CMD_END | 8'h80, 8'h00}; // [RULE12]
            is_opc_r[1] <= 1'b1;
        end
    end
    // kept until next program command or a load [RULE13]

    // frame decode and answer build
    always_ff @(posedge mclk) begin
        if (srst || restart_r) begin
            state_r     <= ICH_IDLE;
            out_idx_r   <= '0;
            out_cnt_r   <= '0;
            ans_kind_r  <= ICH_ANS_ACK;
            ans_word_r  <= '0;
            opcode_r    <= '0;
            rd_sel      <= '0;
        end else begin
            case (state_r)
                ICH_IDLE: begin
                    if (cmd_valid && cmd_last) begin
                        opcode_r <= cmd_first ? cmd_word[7:0]
                                              : words_r[0][7:0];
                        state_r  <= ICH_HEAD;
                    end
                end
                ICH_HEAD: begin
                    out_buf_r[0] <= UNIT_ADDR;          // [RULE16]
                    out_buf_r[1] <= {8'h00, opcode_r};  // [RULE16]
                    out_idx_r    <= '0;
                    ans_word_r   <= UNIT_ADDR; // first word ready on entry
                    ans_kind_r   <= ICH_ANS_DATA;
                    out_cnt_r    <= 4'h2;
                    state_r      <= ICH_BODY;
                    case (opcode_r)
                        ICH_CMD_BUFREAD: begin
                            for (int i = 0; i < 8; i++) begin
                                out_buf_r[2+i] <= flip_opc(
                                    pbuf_r[pb_addr + AW'(i)],
                                    is_opc_r[pb_addr + AW'(i)]); // [RULE1][RULE2]
                            end
                            out_cnt_r <= 4'h2 + ((words_r[1][3:0] >
                                ICH_BUF_LEN_MAX) ? ICH_BUF_LEN_MAX
                                : (words_r[1][3:0] < ICH_BUF_LEN_MIN)
                                ? ICH_BUF_LEN_MIN : words_r[1][3:0]); // [RULE1]
                        end
                        ICH_CMD_REGREAD: begin
                            rd_sel    <= words_r[1][7:0];
                            out_cnt_r <= (nwords_r > 4'h5) ? 4'ha
                                : 4'(5'h2 + {nwords_r - 4'h1, 1'b0}); // [RULE5]
                            state_r   <= ICH_MODIFY_WR;
                        end
                        ICH_CMD_MODIFY: begin
                            rd_sel  <= words_r[2][7:0];
                            state_r <= ICH_MODIFY_WR;
                        end
                        ICH_CMD_VERSION: begin
                            out_buf_r[2] <= {ICH_VER_MONTH, ICH_VER_DAY};
                            out_buf_r[3] <= ICH_VER_YEAR;
                            out_buf_r[4] <= ICH_VER_REV;
                            out_buf_r[5] <= {ICH_SER_SIZE, PB_BYTE}; // [RULE14][RULE15]
                            out_cnt_r    <= 4'h6; // [RULE14]
                        end
                        ICH_CMD_RUN: begin
                            ans_kind_r <= prog_busy ? ICH_ANS_NAK_BUSY
                                                    : ICH_ANS_ACK; // [RULE11]
                            out_cnt_r  <= 4'h1;
                        end
                        ICH_CMD_RESTART: begin
                            state_r <= ICH_IDLE; // no answer [RULE9]
                        end
                        default: begin
                            ans_kind_r <= ICH_ANS_ACK;
                            out_cnt_r  <= 4'h1;
                        end
                    endcase
                end
                ICH_MODIFY_WR: begin
                    // old value is captured on the same edge as the write lands [RULE6]
                    if (opcode_r == ICH_CMD_REGREAD) begin
                        // one register per pass, up to four [RULE5]
                        out_buf_r[rr_slot]        <= rd_data[31:16]; // [RULE4]
                        out_buf_r[rr_slot + 5'h1] <= rd_data[15:0];
                        if (out_idx_r + 4'h2 < nwords_r
                            && out_idx_r + 4'h1 < 4'(ICH_REGREAD_MAX)) begin
                            out_idx_r <= out_idx_r + 4'h1;
                            rd_sel <= words_r[3'(out_idx_r + 4'h2)][7:0];
                        end else begin
                            out_idx_r <= '0;
                            state_r   <= ICH_BODY;
                        end
                    end else begin
                        out_buf_r[2] <= rd_data[31:16];
                        out_buf_r[3] <= rd_data[15:0];
                        out_cnt_r    <= 4'h4;
                        state_r      <= ICH_BODY;
                    end
                end
                ICH_BODY: begin
                    if (ans_ready) begin
                        ans_word_r <= out_buf_r[out_idx_r + 4'h1];
                        if (ans_last) begin
                            state_r <= ICH_IDLE;
                        end
                        out_idx_r <= out_idx_r + 4'h1;
                    end
                end
                default: state_r <= ICH_IDLE;
            endcase
        end
    end

    // run start, program pointer and download mode
    always_ff @(posedge mclk) begin
        if (srst || restart_r) begin
            run_start_r <= 1'b0;
            prog_ptr_r  <= '0;
            download_r  <= 1'b0;
        end else begin
            run_start_r <= 1'b0;
            if (download_set) begin
                download_r <= 1'b1;
            end
            if (state_r == ICH_HEAD && opcode_r == ICH_CMD_RUN
                && !prog_busy) begin
                run_start_r <= 1'b1; // [RULE10]
                prog_ptr_r  <= '0;   // [RULE10]
                download_r  <= 1'b0; // [RULE10]
            end
            if (host_cmd) begin
                run_start_r <= 1'b1; // [RULE12]
                prog_ptr_r  <= '0;   // [RULE12]
            end
        end
    end

    // restart pulse: soft reset of state, data registers and run control
    always_ff @(posedge mclk) begin
        if (srst) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= (state_r == ICH_HEAD)
                         && (opcode_r == ICH_CMD_RESTART); // [RULE8]
        end
    end

    // ======================================================
    // checks
    a_run_busy_nak: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_RUN && prog_busy
        |=> ans_kind_r == ICH_ANS_NAK_BUSY && !run_start_r) // [RULE11]
        else $error("run while busy not refused");
    a_restart_silent: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_RESTART
        |=> !ans_valid ##1 !ans_valid) // [RULE9]
        else $error("restart produced an answer");
    a_restart_clear: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_RESTART
        |=> restart_r ##1 prog_ptr_r == '0 && state_r == ICH_IDLE) // [RULE8]
        else $error("restart did not clear state");
    a_run_start: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_RUN && !prog_busy
        |=> run_start_r && prog_ptr_r == '0 && !download_r) // [RULE10]
        else $error("run did not start at zero");
    a_ver_len: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_VERSION
        |=> out_cnt_r == 4'h6 && out_buf_r[5][7:0] == PB_BYTE) // [RULE14]
        else $error("version answer malformed");
    a_head_echo: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r != ICH_CMD_RESTART
        |=> out_buf_r[0] == UNIT_ADDR
            && out_buf_r[1][7:0] == $past(opcode_r)) // [RULE16]
        else $error("answer header wrong");
    a_buf_len: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_HEAD && opcode_r == ICH_CMD_BUFREAD
        |=> out_cnt_r >= 4'h3 && out_cnt_r <= 4'ha) // [RULE1]
        else $error("buffer read length out of range");
    a_host_run: assert property (@(posedge mclk) disable iff (srst)
        host_cmd && !restart_r |=> run_start_r && prog_ptr_r == '0) // [RULE12]
        else $error("host command did not start");
    a_modify_old: assert property (@(posedge mclk) disable iff (srst)
        state_r == ICH_MODIFY_WR && opcode_r == ICH_CMD_MODIFY
        |=> out_buf_r[3] == $past(rd_data[15:0])) // [RULE6]
        else $error("modify answer not old value");
endmodule // ich_handler

// *** testbench/ich_host_model.sv ***
// host controller model: sends command frames and collects answers
`timescale 1ns/1ns
module ich_host_model (
    input  wire logic        mclk,
    output logic             cmd_valid,
    output logic             cmd_first,
    output logic             cmd_last,
    output logic [15:0]      cmd_word,
    input  wire logic        cmd_ready,
    input  wire logic        ans_valid,
    input  wire logic        ans_last,
    input  wire logic [1:0]  ans_kind_r,
    input  wire logic [15:0] ans_word_r,
    output logic             ans_ready
);
    logic slow = 1'b0;
    // idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_last = 1'b0;
        cmd_word = 16'h0000;
        ans_ready = 1'b0;
    end
    // one frame, each word held until the handler takes it
    task automatic send(input logic [15:0] w[$]);
        for (int i = 0; i < w.size(); i++) begin
            @(negedge mclk);
            cmd_valid = 1'b1;
            cmd_first = (i == 0);
            cmd_last = (i == w.size() - 1);
            cmd_word = w[i];
            while (!cmd_ready) @(negedge mclk);
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_last = 1'b0;
        cmd_word = ~cmd_word; // released word does not keep its value
    endtask
    // collect answer words, stalling every other cycle when slow
    task automatic recv(output logic [15:0] q[$], output logic [1:0] k);
        q = {};
        k = 2'h3;
        for (int n = 0; n < 60; n++) begin
            @(negedge mclk);
            ans_ready = slow ? ~ans_ready : 1'b1;
            #1;
            if (ans_valid && ans_ready) begin
                q.push_back(ans_word_r);
                k = ans_kind_r;
                if (ans_last) break;
            end
        end
    endtask
endmodule // ich_host_model

// *** testbench/ich_handler_tb.sv ***
// testbench for the immediate command handler
`timescale 1ns/1ns
module ich_handler_tb
    import ich_pkg::*;
;
    localparam logic [15:0] UA = 16'h0010;
    logic        mclk, srst, cmd_valid, cmd_first, cmd_last, cmd_ready;
    logic        ans_valid, ans_last, ans_ready, prog_busy, load_we;
    logic        download_set, run_start_r, download_r, restart_r;
    logic        host_mode;
    logic [15:0] cmd_word, ans_word_r, load_word;
    logic [1:0]  ans_kind_r, k;
    logic [8:0]  load_addr, prog_ptr_r;
    logic [15:0] q[$];
    int          failures = 0;
    int          compares = 0;
    int          run_cnt = 0;
    int          rst_cnt = 0;

    ich_handler #(.PB_WORDS(512), .UNIT_ADDR(UA), .AW(9)) ich_handler_inst (
        .mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_word(cmd_word),
        .cmd_ready(cmd_ready), .ans_valid(ans_valid), .ans_last(ans_last),
        .ans_kind_r(ans_kind_r), .ans_word_r(ans_word_r),
        .ans_ready(ans_ready), .prog_busy(prog_busy), .host_mode(host_mode),
        .prog_load(1'b0), .load_we(load_we), .load_addr(load_addr),
        .load_word(load_word), .run_start_r(run_start_r),
        .prog_ptr_r(prog_ptr_r), .download_r(download_r),
        .download_set(download_set), .restart_r(restart_r));
    ich_host_model ich_host_model_inst (
        .mclk(mclk), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
        .cmd_last(cmd_last), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
        .ans_valid(ans_valid), .ans_last(ans_last),
        .ans_kind_r(ans_kind_r), .ans_word_r(ans_word_r),
        .ans_ready(ans_ready));

    // ========================================
    // clock, pulse counters, helpers
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // count single-cycle pulses
    always @(negedge mclk) begin
        if (run_start_r === 1'b1) run_cnt++;
        if (restart_r === 1'b1) rst_cnt++;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic [15:0] w[$]);
        ich_host_model_inst.send(w);
        ich_host_model_inst.recv(q, k);
    endtask
    task automatic hdr(input logic [7:0] c);
        chk("unit", UA, q[0]);
        chk("echo", {8'h00, c}, q[1]);
    endtask
    task automatic rdreg(input logic [15:0] s, input logic [31:0] e);
        xfer('{16'h000c, s});
        hdr(ICH_CMD_REGREAD);
        chk("reg hi", e[31:16], q[2]);
        chk("reg lo", e[15:0], q[3]);
    endtask

    // ========================================
    // scenarios
    task automatic t_bufread();
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            load_we = 1'b1;
            load_addr = 9'(i);
            load_word = {8'h80 | 8'(i), 8'(i)};
        end
        @(negedge mclk);
        load_we = 1'b0;
        load_word = ~load_word;
        xfer('{16'h0006, 16'h0008, 16'h0000});
        hdr(ICH_CMD_BUFREAD);
        chk("buf len", 16'h000a, 16'(q.size()));
        for (int i = 0; i < 8; i++)
            chk("buf word", {8'h80 | 8'(i), 8'(i)}, q[i + 2]);
        xfer('{16'h0006, 16'h0001, 16'h0005});
        chk("one len", 16'h0003, 16'(q.size()));
        chk("one word", 16'h8505, q[2]);
    endtask
    task automatic t_host();
        int n;
        n = run_cnt;
        @(negedge mclk);
        host_mode = 1'b1;
        xfer('{16'h8700});
        host_mode = 1'b0;
        chk("host pulse", 16'(n + 1), 16'(run_cnt));
        xfer('{16'h0006, 16'h0002, 16'h0000});
        chk("host word", 16'h0700, q[2]);
        chk("end word", 16'h0000, q[3]);
        xfer('{16'h000a});
        chk("rerun", 16'(n + 2), 16'(run_cnt));
    endtask
    task automatic t_modify();
        logic [31:0] opd[5] = '{32'hf0, 32'h30, 32'h40, 32'h05, 32'hffc0};
        logic [31:0] old[5] = '{32'h0, 32'hf0, 32'hc0, 32'h40, 32'h45};
        for (int i = 0; i < 5; i++) begin
            xfer('{16'h0020, 16'(i), 16'h000c, opd[i][31:16], opd[i][15:0]});
            hdr(ICH_CMD_MODIFY);
            chk("old hi", old[i][31:16], q[2]);
            chk("old lo", old[i][15:0], q[3]);
        end
        prog_busy = 1'b1;
        rdreg(16'h000c, 32'h0001_0005);
        xfer('{16'h000c, 16'h000c, 16'h00d2, 16'h0001, 16'h0002});
        chk("multi hi", 16'h0001, q[2]);
        chk("multi lo", 16'h0005, q[3]);
        chk("multi len", 16'h000a, 16'(q.size()));
        chk("multi 2 hi", 16'h0200, q[4]);
        chk("multi 2 lo", 16'h0000, q[5]);
        chk("multi 4 lo", 16'h0000, q[9]);
        prog_busy = 1'b0;
    endtask
    task automatic t_version();
        xfer('{16'h0005});
        hdr(ICH_CMD_VERSION);
        chk("date", {ICH_VER_MONTH, ICH_VER_DAY}, q[2]);
        chk("year", ICH_VER_YEAR, q[3]);
        chk("rev", ICH_VER_REV, q[4]);
        chk("sizes", {ICH_SER_SIZE, 8'hff}, q[5]);
        xfer('{16'h000c, 16'h00d2});
        chk("true size", 16'h0200, q[2]);
    endtask
    task automatic t_run();
        int n;
        @(negedge mclk);
        download_set = 1'b1;
        @(negedge mclk);
        download_set = 1'b0;
        chk("download on", 16'h0001, 16'(download_r));
        n = run_cnt;
        xfer('{16'h000a});
        chk("run kind", 16'(ICH_ANS_ACK), 16'(k));
        chk("run pulse", 16'(n + 1), 16'(run_cnt));
        chk("pointer", 16'h0000, 16'(prog_ptr_r));
        chk("download off", 16'h0000, 16'(download_r));
        prog_busy = 1'b1;
        ich_host_model_inst.slow = 1'b1;
        xfer('{16'h000a});
        chk("busy kind", 16'(ICH_ANS_NAK_BUSY), 16'(k));
        chk("busy pulse", 16'(n + 1), 16'(run_cnt));
        prog_busy = 1'b0;
        ich_host_model_inst.slow = 1'b0;
    endtask
    task automatic t_restart();
        int n;
        n = rst_cnt;
        xfer('{16'h0004});
        chk("no answer", 16'h0000, 16'(q.size()));
        chk("restart", 16'(n + 1), 16'(rst_cnt));
        rdreg(16'h000c, 32'h0);
    endtask

    // ========================================
    // verdict, main sequence, watchdog
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        prog_busy = 1'b0;
        load_we = 1'b0;
        load_addr = 9'h000;
        load_word = 16'h0000;
        download_set = 1'b0;
        host_mode = 1'b0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        t_bufread();
        t_host();
        t_modify();
        t_version();
        t_run();
        t_restart();
        print_verdict();
    end
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
endmodule // ich_handler_tb
